// ===== src/plc_pkg.sv
/*
  Constants, types and helpers for the controller supervisory block.
  Assumes a 10 MHz system clock and a 16-bit data word.
*/
// Function
// - debug mode may be entered only from stop mode
// - debug entry clears output image, refreshes inputs, initialises data per restart
// - in debug, I/O refresh follows a pass reaching program end
// - debug halts after one step, at breakpoint, on device condition, or scans
// - in debug each interrupt task is enabled or disabled individually
// - switch positions decode into local run, stop, pause or remote stop
// - switching a running device to local run keeps it running
// - host mode requests are honoured only in remote stop
// - remote transitions allowed: stop-run, stop-debug, run-pause/stop, pause-run/stop, debug-stop
// - remote transitions refused: stop-pause, run/pause-debug, debug-run/pause
// - the stop instruction puts the device into stop mode
// - an internal diagnosis error stops program operation
// - watchdog restarts after end of scan; its period is programmable
// - watchdog times out when program end is not reached in time
// - on timeout all outputs go off, error lamp blinks, run lamp off
// - a detected error writes its code into the system error word
// - global output disable overrides forced output values
// - forcing is per bit and acts only with the global force enable
// - forcing state lives in global bit, enable words and value words
// - forced values replace enabled input bits before the input image
// - forced values drive enabled outputs; output image stays unmodified
// - force settings survive reset, mode changes and stop mode
package plc_pkg;

  typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_PAUSE, MODE_DEBUG}
    op_mode_t;
  typedef enum logic [1:0] {SWM_LOCAL_STOP, SWM_LOCAL_RUN, SWM_LOCAL_PAUSE,
    SWM_REMOTE_STOP} sw_mode_t;
  typedef enum logic [1:0] {POS_STOP, POS_RUN, POS_PAUSE_REMOTE, POS_NONE}
    sw_pos_t;
  typedef enum logic [1:0] {DBG_STEP, DBG_BREAK, DBG_DEVICE, DBG_SCANS}
    dbg_cond_t;

  localparam int IO_BITS       = 64;
  localparam int WORD_BITS     = 16;
  localparam int FORCE_WORDS   = 64;
  localparam int IO_WORDS      = 4;
  localparam int IN_WORD_BASE  = 0;
  localparam int OUT_WORD_BASE = 4;

  // time base: one watchdog tick per millisecond
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BLINK_TICKS = 8'hFA;

  localparam logic [15:0] ERR_WORD_RST = 16'h0000;
  localparam logic [15:0] ERR_CODE_WDT = 16'h0001;

  // remote transition table
  function automatic logic remote_ok(op_mode_t cur, op_mode_t tgt);
    case (cur)
      MODE_STOP:  remote_ok = (tgt == MODE_RUN) || (tgt == MODE_DEBUG);
      MODE_RUN:   remote_ok = (tgt == MODE_PAUSE) || (tgt == MODE_STOP);
      MODE_PAUSE: remote_ok = (tgt == MODE_RUN) || (tgt == MODE_STOP);
      MODE_DEBUG: remote_ok = (tgt == MODE_STOP);
      default:    remote_ok = 1'b0;
    endcase
  endfunction

endpackage

// ===== src/plc_scan_watchdog.sv
/*
  Scan watchdog: counts millisecond ticks while the program executes.
  Assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module plc_scan_watchdog
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic        restart,
  input  wire logic [15:0] period,
  output logic             timeout
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        fired;
    logic        to;
  } wdt_state_t;

  wdt_state_t r;
  wdt_state_t n;

  // count ticks, fire once, re-arm on restart
  always_comb
  begin
    n    = r;
    n.to = 1'b0;
    if (restart)
    begin
      n.cnt   = 16'h0000;
      n.fired = 1'b0;
    end
    else if (enable && tick && !r.fired)
    begin
      n.cnt = r.cnt + 16'h0001;
      if (n.cnt >= period)
      begin
        n.fired = 1'b1;
        n.to    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      r <= '0;
    else
      r <= n;
  end

  assign timeout = r.to;

  property p_wdt_once;
    @(posedge clk) disable iff (reset)
    (r.fired && !restart) |=> !timeout;
  endproperty
  a_wdt_once: assert property (p_wdt_once)
    else $error("watchdog fired twice without restart");

  property p_wdt_fire;
    @(posedge clk) disable iff (reset)
    (enable && tick && !restart && !r.fired && (r.cnt + 16'h0001 >= period))
      |=> timeout;
  endproperty
  a_wdt_fire: assert property (p_wdt_fire)
    else $error("watchdog missed its period");

endmodule
`default_nettype wire

// ===== src/plc_supervisor.sv
/*
  Controller supervisor: operating mode, mode switch, remote requests,
  debug control, watchdog handling and forced I/O at refresh.
  Assumes program-side strobes are one-cycle pulses on SYS_CLK.
*/
`timescale 1ns/10ps
`default_nettype none
module plc_supervisor
#(
  parameter int TICK_CYCLES = plc_pkg::TICK_CYC
)
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // pins
  input  wire logic [1:0]  MODE_SW,
  input  wire logic [63:0] IN_PINS,
  output logic      [63:0] OUT_PINS,
  output logic             RUN_LED,
  output logic             ERR_LED,
  // host requests
  input  wire logic        REQ_VALID,
  input  wire logic [1:0]  REQ_MODE,
  output logic             REQ_ACK,
  output logic             REQ_NAK,
  // program side
  input  wire logic        END_SCAN,
  input  wire logic        STOP_INSTR,
  input  wire logic        WDT_INSTR,
  input  wire logic        OUT_DISABLE,
  input  wire logic [63:0] OUT_IMAGE,
  input  wire logic [15:0] WDT_PERIOD,
  output logic [1:0]       MODE,
  output logic             PROG_EXEC,
  output logic [63:0]      IN_IMAGE,
  output logic             OUT_IMAGE_CLR,
  output logic             IN_REFRESH,
  output logic             IO_REFRESH,
  output logic             DATA_INIT,
  output logic             DATA_INIT_MODE,
  // debug control
  input  wire logic        RESTART_MODE,
  input  wire logic [1:0]  DBG_COND,
  input  wire logic [15:0] DBG_SCANS,
  input  wire logic        DBG_GO,
  input  wire logic        INSTR_DONE,
  input  wire logic        BREAK_HIT,
  input  wire logic        DEV_COND_HIT,
  input  wire logic [7:0]  INT_TASK_EN,
  output logic [7:0]       INT_TASK_RUN,
  // diagnosis
  input  wire logic        DIAG_ERR,
  input  wire logic [15:0] DIAG_CODE,
  output logic [15:0]      ERR_FLAG_WORD,
  // force settings
  input  wire logic        FORCE_GLOBAL_EN,
  input  wire logic        FORCE_WE,
  input  wire logic        FORCE_SEL,
  input  wire logic [5:0]  FORCE_ADDR,
  input  wire logic [15:0] FORCE_WDATA
);

  typedef struct packed {
    logic [63:0]        pin_s1;
    logic [63:0]        pin_s2;
    logic [63:0]        pin_s3;
    logic [63:0]        pin_ok;
    logic [1:0]         sw_s1;
    logic [1:0]         sw_s2;
    logic [1:0]         sw_s3;
    plc_pkg::sw_pos_t   sw_pos;
    plc_pkg::sw_pos_t   sw_last;
    plc_pkg::sw_mode_t  sw_mode;
    plc_pkg::op_mode_t  mode;
    logic               fault;
    logic               wdt_flt;
    logic [15:0]        err;
    logic               dbg_run;
    logic [15:0]        scans;
    logic [15:0]        div;
    logic               tick;
    logic [7:0]         bcnt;
    logic               blink;
    logic [63:0]        in_img;
    logic [63:0]        out;
    logic               exec;
    logic               run_led;
    logic               err_led;
    logic               ack;
    logic               nak;
    logic               clr_out;
    logic               in_ref;
    logic               io_ref;
    logic               dinit;
    logic               dinit_mode;
    logic [7:0]         int_run;
  } sup_state_t;

  sup_state_t r;
  sup_state_t n;

  // force words; no reset so settings outlive reset and mode changes
  logic [15:0] fen_mem [plc_pkg::FORCE_WORDS];
  logic [15:0] fval_mem [plc_pkg::FORCE_WORDS];
  logic [63:0] fen_in;
  logic [63:0] fval_in;
  logic [63:0] fen_out;
  logic [63:0] fval_out;
  logic [63:0] in_forced;
  logic [63:0] out_drive;
  logic        wdt_to;
  logic        sw_chg;
  logic        fault_now;
  logic        stop_hit;
  logic        req_ok;
  logic        quiet;
  logic        do_oref;
  plc_pkg::op_mode_t req_mode;
  plc_pkg::op_mode_t cur_mode;

  // host tool writes enable and value words at any address
  always_ff @(posedge SYS_CLK)
  begin
    if (FORCE_WE && !FORCE_SEL)
      fen_mem[FORCE_ADDR] <= FORCE_WDATA;
    if (FORCE_WE && FORCE_SEL)
      fval_mem[FORCE_ADDR] <= FORCE_WDATA;
  end

  // gather per-bit masks, gated by the global enable
  for (genvar g = 0; g < plc_pkg::IO_WORDS; g++)
  begin : g_force
    assign fen_in[g*16 +: 16]   = fen_mem[plc_pkg::IN_WORD_BASE + g]
                                  & {16{FORCE_GLOBAL_EN}};
    assign fval_in[g*16 +: 16]  = fval_mem[plc_pkg::IN_WORD_BASE + g];
    assign fen_out[g*16 +: 16]  = fen_mem[plc_pkg::OUT_WORD_BASE + g]
                                  & {16{FORCE_GLOBAL_EN}};
    assign fval_out[g*16 +: 16] = fval_mem[plc_pkg::OUT_WORD_BASE + g];
  end

  // forced substitution on input and output paths
  assign in_forced = (r.pin_ok & ~fen_in) | (fval_in & fen_in);
  assign out_drive = OUT_DISABLE ? 64'h0000000000000000
                   : (OUT_IMAGE & ~fen_out) | (fval_out & fen_out);

  // event qualifiers
  assign req_mode  = plc_pkg::op_mode_t'(REQ_MODE);
  assign cur_mode  = r.mode;
  assign sw_chg    = (r.sw_pos != r.sw_last);
  assign fault_now = DIAG_ERR || wdt_to;
  assign stop_hit  = STOP_INSTR && r.exec;
  assign req_ok    = (r.sw_mode == plc_pkg::SWM_REMOTE_STOP)
                     && plc_pkg::remote_ok(r.mode, req_mode);
  assign quiet     = !fault_now && !r.fault && !stop_hit && !sw_chg;
  assign do_oref   = ((r.mode == plc_pkg::MODE_RUN) && END_SCAN)
                   || ((r.mode == plc_pkg::MODE_DEBUG) && END_SCAN)
                   || ((r.mode == plc_pkg::MODE_STOP) && r.tick)
                   || ((r.mode == plc_pkg::MODE_PAUSE) && r.tick);

  plc_scan_watchdog u_wdt
  (
    .clk     (SYS_CLK),
    .reset   (RESET),
    .tick    (r.tick),
    .enable  (r.exec),
    .restart (END_SCAN || WDT_INSTR),
    .period  (WDT_PERIOD),
    .timeout (wdt_to)
  );

  // next-state logic for the whole supervisor
  always_comb
  begin
    n         = r;
    n.ack     = 1'b0;
    n.nak     = 1'b0;
    n.clr_out = 1'b0;
    n.in_ref  = 1'b0;
    n.io_ref  = 1'b0;
    n.dinit   = 1'b0;
    n.tick    = 1'b0;
    // pin synchronisers: take a bit once stages two and three agree
    n.pin_s1 = IN_PINS;
    n.pin_s2 = r.pin_s1;
    n.pin_s3 = r.pin_s2;
    n.pin_ok = (r.pin_s3 & ~(r.pin_s2 ^ r.pin_s3))
             | (r.pin_ok & (r.pin_s2 ^ r.pin_s3));
    n.sw_s1  = MODE_SW;
    n.sw_s2  = r.sw_s1;
    n.sw_s3  = r.sw_s2;
    if ((r.sw_s2 == r.sw_s3) && (r.sw_s3 != 2'h3))
      n.sw_pos = plc_pkg::sw_pos_t'(r.sw_s3);
    // millisecond divider and lamp blink
    n.div = r.div + 16'h0001;
    if (r.div == 16'(TICK_CYCLES - 1))
    begin
      n.div  = 16'h0000;
      n.tick = 1'b1;
    end
    if (r.tick)
    begin
      n.bcnt = r.bcnt + 8'h01;
      if (r.bcnt == plc_pkg::BLINK_TICKS - 8'h01)
      begin
        n.bcnt  = 8'h00;
        n.blink = !r.blink;
      end
    end
    // switch decode
    n.sw_last = r.sw_pos;
    if (sw_chg)
    begin
      case (r.sw_pos)
        plc_pkg::POS_RUN:  n.sw_mode = plc_pkg::SWM_LOCAL_RUN;
        plc_pkg::POS_STOP: n.sw_mode = plc_pkg::SWM_LOCAL_STOP;
        plc_pkg::POS_PAUSE_REMOTE:
          n.sw_mode = (r.sw_last == plc_pkg::POS_RUN)
                    ? plc_pkg::SWM_LOCAL_PAUSE : plc_pkg::SWM_REMOTE_STOP;
        default: n.sw_mode = r.sw_mode;
      endcase
    end
    // mode selection: fault, stop instruction, switch, host request
    if (fault_now)
    begin
      n.fault = 1'b1;
      n.mode  = plc_pkg::MODE_STOP;
      n.err   = DIAG_ERR ? DIAG_CODE : plc_pkg::ERR_CODE_WDT;
      if (wdt_to)
        n.wdt_flt = 1'b1;
    end
    else if (r.fault)
      n.mode = plc_pkg::MODE_STOP;
    else if (stop_hit)
      n.mode = plc_pkg::MODE_STOP;
    else if (sw_chg)
    begin
      case (n.sw_mode)
        plc_pkg::SWM_LOCAL_RUN: n.mode = plc_pkg::MODE_RUN;
        plc_pkg::SWM_LOCAL_PAUSE:
          n.mode = (r.mode == plc_pkg::MODE_RUN) ? plc_pkg::MODE_PAUSE
                 : r.mode;
        default: n.mode = plc_pkg::MODE_STOP;
      endcase
    end
    else if (REQ_VALID && req_ok)
    begin
      n.mode = req_mode;
      n.ack  = 1'b1;
    end
    n.nak = REQ_VALID && !(quiet && req_ok);
    // entry actions
    if (n.mode != r.mode)
    begin
      n.dbg_run = 1'b0;
      if (n.mode == plc_pkg::MODE_STOP)
        n.clr_out = 1'b1;
      if (n.mode == plc_pkg::MODE_DEBUG)
      begin
        n.clr_out    = 1'b1;
        n.in_ref     = 1'b1;
        n.dinit      = 1'b1;
        n.dinit_mode = RESTART_MODE;
      end
    end
    // debug run control and halt conditions
    else if (r.mode == plc_pkg::MODE_DEBUG)
    begin
      if (!r.dbg_run && DBG_GO)
      begin
        n.dbg_run = 1'b1;
        n.scans   = DBG_SCANS;
      end
      else if (r.dbg_run)
      begin
        if (END_SCAN && (r.scans != 16'h0000))
          n.scans = r.scans - 16'h0001;
        case (plc_pkg::dbg_cond_t'(DBG_COND))
          plc_pkg::DBG_STEP:   n.dbg_run = !INSTR_DONE;
          plc_pkg::DBG_BREAK:  n.dbg_run = !BREAK_HIT;
          plc_pkg::DBG_DEVICE: n.dbg_run = !DEV_COND_HIT;
          plc_pkg::DBG_SCANS:
            n.dbg_run = !(END_SCAN && (r.scans <= 16'h0001));
          default: n.dbg_run = 1'b0;
        endcase
      end
    end
    n.exec = !fault_now && ((n.mode == plc_pkg::MODE_RUN)
           || ((n.mode == plc_pkg::MODE_DEBUG) && n.dbg_run));
    // refresh of both images
    n.io_ref = do_oref;
    if (do_oref || n.in_ref)
      n.in_img = in_forced;
    if (r.wdt_flt || wdt_to)
      n.out = 64'h0000000000000000;
    else if (do_oref || OUT_DISABLE)
      n.out = out_drive;
    // lamps and interrupt task gating
    n.run_led = (n.mode == plc_pkg::MODE_RUN) && !n.wdt_flt;
    n.err_led = n.wdt_flt ? r.blink : n.fault;
    n.int_run = (n.mode == plc_pkg::MODE_DEBUG) ? INT_TASK_EN : 8'hFF;
  end

  // state register; reset gives stop mode with outputs off
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      r      <= '0;
      r.err  <= plc_pkg::ERR_WORD_RST;
      r.int_run <= 8'hFF;
    end
    else
      r <= n;
  end

  assign OUT_PINS       = r.out;
  assign RUN_LED        = r.run_led;
  assign ERR_LED        = r.err_led;
  assign REQ_ACK        = r.ack;
  assign REQ_NAK        = r.nak;
  assign MODE           = r.mode;
  assign PROG_EXEC      = r.exec;
  assign IN_IMAGE       = r.in_img;
  assign OUT_IMAGE_CLR  = r.clr_out;
  assign IN_REFRESH     = r.in_ref;
  assign IO_REFRESH     = r.io_ref;
  assign DATA_INIT      = r.dinit;
  assign DATA_INIT_MODE = r.dinit_mode;
  assign INT_TASK_RUN   = r.int_run;
  assign ERR_FLAG_WORD  = r.err;

  sequence s_enter_debug;
    (cur_mode != plc_pkg::MODE_DEBUG) ##1 (cur_mode == plc_pkg::MODE_DEBUG);
  endsequence

  property p_dbg_from_stop;
    @(posedge SYS_CLK) disable iff (RESET)
    s_enter_debug |-> $past(cur_mode) == plc_pkg::MODE_STOP;
  endproperty
  a_dbg_from_stop: assert property (p_dbg_from_stop)
    else $error("debug entered from a mode other than stop");

  property p_dbg_init;
    @(posedge SYS_CLK) disable iff (RESET)
    s_enter_debug |-> OUT_IMAGE_CLR && IN_REFRESH && DATA_INIT;
  endproperty
  a_dbg_init: assert property (p_dbg_init)
    else $error("debug entry without clear, refresh and init");

  property p_refused;
    @(posedge SYS_CLK) disable iff (RESET)
    (REQ_VALID && quiet && !req_ok) |=> $stable(cur_mode) && REQ_NAK;
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused request changed the mode");

  property p_accept;
    @(posedge SYS_CLK) disable iff (RESET)
    (REQ_VALID && quiet && req_ok) |=> REQ_ACK
      && (cur_mode == $past(req_mode));
  endproperty
  a_accept: assert property (p_accept)
    else $error("permitted request not carried out");

  property p_stop_instr;
    @(posedge SYS_CLK) disable iff (RESET)
    stop_hit |=> (cur_mode == plc_pkg::MODE_STOP) && !PROG_EXEC;
  endproperty
  a_stop_instr: assert property (p_stop_instr)
    else $error("stop instruction did not stop");

  property p_diag;
    @(posedge SYS_CLK) disable iff (RESET)
    DIAG_ERR |=> (cur_mode == plc_pkg::MODE_STOP)
      && (ERR_FLAG_WORD == $past(DIAG_CODE));
  endproperty
  a_diag: assert property (p_diag)
    else $error("diagnosis error not handled");

  sequence s_outputs_dead;
    (OUT_PINS == 64'h0000000000000000) && !RUN_LED;
  endsequence

  property p_wdt_off;
    @(posedge SYS_CLK) disable iff (RESET)
    wdt_to |=> s_outputs_dead [*8];
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("outputs or run lamp on after watchdog timeout");

  property p_force_out;
    @(posedge SYS_CLK) disable iff (RESET)
    (do_oref && !OUT_DISABLE && !wdt_to && !r.wdt_flt) |=>
      OUT_PINS == (($past(OUT_IMAGE) & ~$past(fen_out))
                   | ($past(fval_out) & $past(fen_out)));
  endproperty
  a_force_out: assert property (p_force_out)
    else $error("forced output mismatch");

  property p_global_output_disable_instr;
    @(posedge SYS_CLK) disable iff (RESET)
    OUT_DISABLE |=> OUT_PINS == 64'h0000000000000000;
  endproperty
  a_global_output_disable_instr: assert property (p_global_output_disable_instr)
    else $error("output disable lost to forcing");

endmodule
`default_nettype wire

// ===== testbench/plc_program_model.sv
/*
  User program model: ends a scan every period cycles while run is high
  and issues a watchdog restart halfway through each scan.
  Assumes it shares the supervisor clock.
*/
`timescale 1ns/10ps
`default_nettype none
module plc_program_model
(
  // clock
  input  wire logic       clk,
  // control from the bench
  input  wire logic       run,
  input  wire logic [7:0] period,
  // program strobes
  output logic            end_scan,
  output logic            wdt_instr
);
  logic [7:0] cnt;

  // scan pacing, long loops keep the watchdog alive
  always @(posedge clk)
  begin
    end_scan  <= run && (cnt == period);
    wdt_instr <= run && (cnt == (period >> 1));
    cnt       <= (!run || cnt == period) ? 8'h01 : cnt + 8'h01;
  end
endmodule
`default_nettype wire

// ===== testbench/plc_supervisor_tb_top.sv
/*
  Self-checking bench for the supervisor block.
  Assumes a 10-cycle tick and the program model beside the design.
*/
`timescale 1ns/10ps
`default_nettype none
module plc_supervisor_tb_top;
  // design and bench signals
  logic        SYS_CLK, RESET, REQ_VALID, END_SCAN, STOP_INSTR, WDT_INSTR;
  logic        OUT_DISABLE, RESTART_MODE, DBG_GO, INSTR_DONE, BREAK_HIT;
  logic        DEV_COND_HIT, DIAG_ERR, FORCE_GLOBAL_EN, FORCE_WE, FORCE_SEL;
  logic        RUN_LED, ERR_LED, REQ_ACK, REQ_NAK, PROG_EXEC, OUT_IMAGE_CLR;
  logic        IN_REFRESH, IO_REFRESH, DATA_INIT, DATA_INIT_MODE, prun, flg;
  logic [1:0]  MODE_SW, REQ_MODE, MODE, DBG_COND, em;
  logic [5:0]  FORCE_ADDR;
  logic [7:0]  INT_TASK_EN, INT_TASK_RUN, pper;
  logic [15:0] WDT_PERIOD, DBG_SCANS, DIAG_CODE, ERR_FLAG_WORD, FORCE_WDATA;
  logic [15:0] fen, fv, pin, oim;
  logic [63:0] IN_PINS, OUT_PINS, OUT_IMAGE, IN_IMAGE;
  logic [2:0]  expq [$];
  int          bad_count, checks, i, c, t;
  // remote transitions allowed, indexed by {current, target}
  localparam logic [15:0] REMOTE_MAP = 16'h135A;

  plc_supervisor #(.TICK_CYCLES(10)) u_plc_supervisor
  (
    .SYS_CLK, .RESET, .MODE_SW, .IN_PINS, .OUT_PINS, .RUN_LED, .ERR_LED,
    .REQ_VALID, .REQ_MODE, .REQ_ACK, .REQ_NAK, .END_SCAN, .STOP_INSTR,
    .WDT_INSTR, .OUT_DISABLE, .OUT_IMAGE, .WDT_PERIOD, .MODE, .PROG_EXEC,
    .IN_IMAGE, .OUT_IMAGE_CLR, .IN_REFRESH, .IO_REFRESH, .DATA_INIT,
    .DATA_INIT_MODE, .RESTART_MODE, .DBG_COND, .DBG_SCANS, .DBG_GO,
    .INSTR_DONE, .BREAK_HIT, .DEV_COND_HIT, .INT_TASK_EN, .INT_TASK_RUN,
    .DIAG_ERR, .DIAG_CODE, .ERR_FLAG_WORD, .FORCE_GLOBAL_EN, .FORCE_WE,
    .FORCE_SEL, .FORCE_ADDR, .FORCE_WDATA
  );

  plc_program_model u_plc_program_model
  (
    .clk(SYS_CLK), .run(prun), .period(pper), .end_scan(END_SCAN),
    .wdt_instr(WDT_INSTR)
  );

  // 10 MHz clock
  initial
  begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  task automatic results;
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // step n edges, then settle
  task automatic tk(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic rst;
    RESET = 1'b1;
    tk(6);
    RESET = 1'b0;
    em = 2'h0;
    tk(8);
  endtask

  // host request; rem says whether the switch gives remote stop
  task automatic req(input logic [1:0] m, input logic rem);
    logic ok;
    ok = rem && REMOTE_MAP[{em, m}];
    expq.push_back({ok, ok ? m : em});
    em = ok ? m : em;
    REQ_VALID = 1'b1;
    REQ_MODE = m;
    tk(1);
    REQ_VALID = 1'b0;
    tk(1);
  endtask

  // pulse one debug event: 0 step, 1 break, 2 device, 3 go
  task automatic hit(input int k, input logic e);
    {INSTR_DONE, BREAK_HIT, DEV_COND_HIT, DBG_GO} = 4'(1 << (3 - k));
    tk(1);
    {INSTR_DONE, BREAK_HIT, DEV_COND_HIT, DBG_GO} = 4'h0;
    tk(1);
    cmp("exec", 64'(e), 64'(PROG_EXEC));
  endtask

  task automatic fw(input logic s, input logic [5:0] a, input logic [15:0] d);
    FORCE_WE = 1'b1;
    FORCE_SEL = s;
    FORCE_ADDR = a;
    FORCE_WDATA = d;
    tk(1);
    FORCE_WE = 1'b0;
    tk(1);
  endtask

  task automatic fchk(input logic g);
    logic [15:0] m;
    m = g ? fen : 16'h0000;
    tk(30);
    cmp("in_image", 64'((pin & ~m) | (fv & m)), 64'(IN_IMAGE[15:0]));
    cmp("out_pins", 64'((oim & ~m) | (fv & m)), 64'(OUT_PINS[15:0]));
  endtask

  // answers are paired with the oldest note, sampled mid-cycle
  always @(negedge SYS_CLK)
  begin
    if (REQ_ACK === 1'b1 || REQ_NAK === 1'b1)
    begin
      if (expq.size() == 0)
        cmp("unasked", 64'h1, 64'h0);
      else
        cmp("answer", 64'(expq.pop_front()), 64'({REQ_ACK, MODE}));
    end
    if (REQ_ACK === 1'b1 && MODE === 2'h3)
      cmp("dbg_entry", 64'({3'h7, RESTART_MODE}), 64'({OUT_IMAGE_CLR, IN_REFRESH, DATA_INIT, DATA_INIT_MODE}));
  end

  // main sequence
  initial
  begin
    {REQ_VALID, STOP_INSTR, OUT_DISABLE, DBG_GO, INSTR_DONE, BREAK_HIT,
     DEV_COND_HIT, DIAG_ERR, FORCE_GLOBAL_EN, FORCE_WE, FORCE_SEL} = '0;
    {REQ_MODE, DBG_COND, FORCE_ADDR, FORCE_WDATA, prun} = '0;
    bad_count = 0;
    checks = 0;
    pin = 16'($urandom(69));
    fen = 16'($urandom());
    fv = 16'($urandom());
    oim = 16'($urandom());
    RESTART_MODE = 1'($urandom());
    INT_TASK_EN = 8'($urandom());
    DIAG_CODE = 16'($urandom()) | 16'h8000;
    IN_PINS = {$urandom(), 16'($urandom()), pin};
    OUT_IMAGE = {48'h0, oim};
    MODE_SW = plc_pkg::POS_STOP;
    WDT_PERIOD = 16'h0FFF;
    DBG_SCANS = 16'h0001;
    pper = 8'h0F;
    rst();
    cmp("reset", 64'h00FF0000, 64'({MODE, INT_TASK_RUN, ERR_FLAG_WORD}));
    req(2'h1, 1'b0);
    MODE_SW = plc_pkg::POS_PAUSE_REMOTE;
    tk(8);
    // every remote transition from every mode
    for (c = 0; c < 4; c++)
      for (t = 0; t < 4; t++)
      begin
        if (c == 1 || c == 2)
          req(2'h1, 1'b1);
        if (c > 1)
          req(2'(c), 1'b1);
        req(2'(t), 1'b1);
        if (em != 2'h0)
          req(2'h0, 1'b1);
      end
    // debug passes under each stop condition
    req(2'h3, 1'b1);
    cmp("int_tasks", 64'(INT_TASK_EN), 64'(INT_TASK_RUN));
    for (c = 0; c < 3; c++)
    begin
      DBG_COND = 2'(c);
      hit(3, 1'b1);
      hit((c + 1) % 3, 1'b1);
      hit(c, 1'b0);
    end
    DBG_COND = 2'h3;
    hit(3, 1'b1);
    prun = 1'b1;
    for (i = 0; i < 40 && END_SCAN !== 1'b1; i++)
      tk(1);
    prun = 1'b0;
    tk(1);
    cmp("scan_end", 64'h2, 64'({IO_REFRESH, PROG_EXEC}));
    req(2'h0, 1'b1);
    // switch to run while running, then local pause and stop
    req(2'h1, 1'b1);
    MODE_SW = plc_pkg::POS_RUN;
    flg = 1'b0;
    repeat (10)
    begin
      tk(1);
      flg = flg | (PROG_EXEC !== 1'b1);
    end
    cmp("local_run", 64'h1, 64'({flg, MODE}));
    req(2'h0, 1'b0);
    MODE_SW = plc_pkg::POS_PAUSE_REMOTE;
    tk(8);
    cmp("local_pause", 64'h2, 64'(MODE));
    MODE_SW = plc_pkg::POS_STOP;
    tk(8);
    cmp("local_stop", 64'h0, 64'(MODE));
    em = 2'h0;
    MODE_SW = plc_pkg::POS_PAUSE_REMOTE;
    tk(8);
    req(2'h1, 1'b1);
    STOP_INSTR = 1'b1;
    tk(1);
    STOP_INSTR = 1'b0;
    tk(1);
    em = 2'h0;
    cmp("stop_instr", 64'h0, 64'(MODE));
    // forcing on inputs and outputs
    for (i = 0; i < 8; i++)
    begin
      fw(1'b0, 6'(i), (i % 4 == 0) ? fen : 16'h0000);
      fw(1'b1, 6'(i), fv);
    end
    fchk(1'b0);
    FORCE_GLOBAL_EN = 1'b1;
    fchk(1'b1);
    OUT_DISABLE = 1'b1;
    tk(2);
    cmp("out_off", 64'h0, OUT_PINS);
    OUT_DISABLE = 1'b0;
    // watchdog kept alive, then starved
    WDT_PERIOD = 16'h0003;
    // let the program restart the watchdog before run begins
    prun = 1'b1;
    tk(10);
    req(2'h1, 1'b1);
    tk(200);
    cmp("wdt_alive", 64'h3, 64'({MODE, RUN_LED}));
    prun = 1'b0;
    for (i = 0; i < 60 && MODE !== 2'h0; i++)
      tk(1);
    em = 2'h0;
    cmp("wdt_fire", 64'h0, 64'({MODE, RUN_LED}));
    cmp("wdt_outs", 64'h0, OUT_PINS);
    cmp("wdt_code", 64'h1, 64'(ERR_FLAG_WORD));
    flg = ERR_LED;
    for (i = 0; i < 6000 && ERR_LED === flg; i++)
      tk(1);
    cmp("blink", 64'(!flg), 64'(ERR_LED));
    // settings survive reset
    rst();
    fchk(1'b1);
    req(2'h1, 1'b1);
    DIAG_ERR = 1'b1;
    tk(1);
    DIAG_ERR = 1'b0;
    tk(1);
    em = 2'h0;
    cmp("diag", 64'({3'h1, DIAG_CODE}), 64'({MODE, ERR_LED, ERR_FLAG_WORD}));
    tk(4);
    cmp("pending", 64'h0, 64'(expq.size()));
    results();
  end
endmodule
`default_nettype wire
